// >>> verilog/addr_seq_pkg.sv
package addr_seq_pkg;

  // reset values and the 16-bit increment step
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] STEP_ONE = 16'h0001;

  // operand addressing modes served here
  typedef enum logic [1:0] {
    MODE_BIG_ABS    = 2'b00,
    MODE_INDEXED    = 2'b01,
    MODE_INDIRECT   = 2'b10,
    MODE_PREINDEXED = 2'b11
  } mode_type;

  // decoded instruction classes handed in by the core
  typedef enum logic [4:0] {
    OP_ADD                  = 5'b00000,
    OP_ADD_WITH_CARRY       = 5'b00001,
    OP_AND                  = 5'b00010,
    OP_COMPARE_WORKING_REG  = 5'b00011,
    OP_LOAD_WORKING_REG     = 5'b00100,
    OP_OR                   = 5'b00101,
    OP_STORE_WORKING_REG    = 5'b00110,
    OP_SUB                  = 5'b00111,
    OP_SUBTRACT_WITH_BORROW = 5'b01000,
    OP_XOR                  = 5'b01001,
    OP_JUMP_ALWAYS          = 5'b01010,
    OP_CALL_SUBROUTINE      = 5'b01011,
    OP_WIDE_LOAD_STACK_PTR  = 5'b01100,
    OP_WIDE_LOAD_OFFSET_REG = 5'b01101,
    OP_WIDE_LOAD_VECTOR     = 5'b01110,
    OP_WIDE_STORE_STACK_PTR = 5'b01111,
    OP_WIDE_STORE_OFFSET_REG = 5'b10000
  } op_type;

  // sequencer states, one memory access in each state except idle and done
  typedef enum logic [3:0] {
    ST_IDLE     = 4'b0000,
    ST_OPCODE   = 4'b0001,
    ST_ADDR_HI  = 4'b0010,
    ST_ADDR_LO  = 4'b0011,
    ST_PTR_HI   = 4'b0100,
    ST_PTR_LO   = 4'b0101,
    ST_DATA     = 4'b0110,
    ST_WIDE_HI  = 4'b0111,
    ST_WIDE_LO  = 4'b1000,
    ST_DONE     = 4'b1001
  } state_type;

endpackage

// >>> verilog/wrap_adder16.sv
`timescale 1ns/1ps
// 16-bit adder whose carry out is dropped, so sums wrap modulo 65536
module wrap_adder16 (
  input wire logic [15:0] i_a,
  input wire logic [15:0] i_b,
  output logic [15:0] o_sum
);

  logic [16:0] full_sum;

  // low-byte carry ripples into the high byte; bit 16 is discarded
  assign full_sum = {1'b0, i_a} + {1'b0, i_b};
  assign o_sum = full_sum[15:0];

endmodule

// >>> verilog/cpu_addressing_sequencer.sv
`timescale 1ns/1ps
module cpu_addressing_sequencer
  import addr_seq_pkg::*;
(
  input wire logic I_REF_CLK,
  input wire logic I_RSTN,
  input wire logic I_START,
  input wire logic [1:0] I_MODE,
  input wire logic [4:0] I_OP,
  input wire logic I_CARRY,
  input wire logic [7:0] I_MEM_RDATA,
  output logic [15:0] O_MEM_ADDR,
  output logic O_MEM_RD,
  output logic O_MEM_WR,
  output logic [7:0] O_MEM_WDATA,
  output logic O_BUSY,
  output logic O_DONE,
  output logic O_ILLEGAL,
  output logic [15:0] O_PROGRAM_COUNTER,
  output logic [7:0] O_OPCODE_HOLDING_REGISTER,
  output logic [7:0] O_WORKING_REGISTER,
  output logic [15:0] O_INDEX_REG,
  output logic [15:0] O_STACK_POINTER,
  output logic [15:0] O_INTERRUPT_VECTOR
);

  state_type state_q, state_d;
  mode_type mode_q, mode_d;
  op_type op_q, op_d;
  logic [15:0] pc_q, pc_d;
  logic [7:0] ir_q, ir_d;
  logic [15:0] temp_a_q, temp_a_d;
  logic [15:0] temp_b_q, temp_b_d;
  logic [15:0] index_q, index_d;
  logic [15:0] sp_q, sp_d;
  logic [15:0] iv_q, iv_d;
  logic [7:0] work_q, work_d;
  logic [15:0] addr_q, addr_d;
  logic rd_q, rd_d;
  logic wr_q, wr_d;
  logic [7:0] wdata_q, wdata_d;
  logic done_q, done_d;
  logic busy_q, busy_d;
  logic illegal_q, illegal_d;
  logic [15:0] operand_addr;
  logic [15:0] indexed_sum;
  logic [15:0] wide_src;

  // legal mode and class pairs; anything else is refused at start
  function automatic logic is_legal(input mode_type m, input op_type o);
    logic ok;
    ok = 1'b0;
    case (m)
      MODE_BIG_ABS: ok = (o >= OP_WIDE_LOAD_STACK_PTR) && (o <= OP_WIDE_STORE_OFFSET_REG);
      MODE_INDEXED: ok = (o <= OP_CALL_SUBROUTINE);
      default: ok = (o == OP_LOAD_WORKING_REG) || (o == OP_STORE_WORKING_REG) ||
                    (o == OP_JUMP_ALWAYS) || (o == OP_CALL_SUBROUTINE);
    endcase
    return ok;
  endfunction

  // jump and call both just take a new program counter here
  function automatic logic is_jump(input op_type o);
    return (o == OP_JUMP_ALWAYS) || (o == OP_CALL_SUBROUTINE);
  endfunction

  // the wide stores only write memory
  function automatic logic is_wide_store(input op_type o);
    return (o == OP_WIDE_STORE_STACK_PTR) || (o == OP_WIDE_STORE_OFFSET_REG);
  endfunction

  // byte operation on the working register; compare leaves it untouched
  function automatic logic [7:0] alu(input op_type o, input logic [7:0] a, input logic [7:0] b,
                                     input logic c);
    logic [7:0] r;
    r = a;
    case (o)
      OP_ADD: r = a + b;
      OP_ADD_WITH_CARRY: r = a + b + {7'h00, c};
      OP_AND: r = a & b;
      OP_LOAD_WORKING_REG: r = b;
      OP_OR: r = a | b;
      OP_SUB: r = a - b;
      OP_SUBTRACT_WITH_BORROW: r = a - b - {7'h00, c};
      OP_XOR: r = a ^ b;
      default: r = a;
    endcase
    return r;
  endfunction

  // operand address assembled from the latched high half and the low byte now on the bus
  assign operand_addr = {temp_a_q[15:8], I_MEM_RDATA};
  assign wide_src = (op_q == OP_WIDE_STORE_STACK_PTR) ? sp_q : index_q;

  // operand plus index, wrapping; index register only read
  wrap_adder16 u_index_add (
    .i_a(operand_addr),
    .i_b(index_q),
    .o_sum(indexed_sum)
  );

  // next-state and datapath; memory is read combinationally in the cycle its strobe is high
  always_comb begin
    state_d = state_q;
    mode_d = mode_q;
    op_d = op_q;
    pc_d = pc_q;
    ir_d = ir_q;
    temp_a_d = temp_a_q;
    temp_b_d = temp_b_q;
    // index changes only by a wide load
    index_d = index_q;
    sp_d = sp_q;
    iv_d = iv_q;
    work_d = work_q;
    addr_d = addr_q;
    rd_d = 1'b0;
    wr_d = 1'b0;
    wdata_d = wdata_q;
    done_d = 1'b0;
    busy_d = busy_q;
    illegal_d = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (I_START) begin
          if (is_legal(mode_type'(I_MODE), op_type'(I_OP))) begin
            mode_d = mode_type'(I_MODE);
            op_d = op_type'(I_OP);
            addr_d = pc_q;
            rd_d = 1'b1;
            busy_d = 1'b1;
            state_d = ST_OPCODE;
          end else begin
            illegal_d = 1'b1;
          end
        end
      end
      // opcode fetch then high address byte
      ST_OPCODE: begin
        ir_d = I_MEM_RDATA;
        pc_d = pc_q + STEP_ONE;
        addr_d = pc_q + STEP_ONE;
        rd_d = 1'b1;
        state_d = ST_ADDR_HI;
      end
      // high byte into counter A high half
      ST_ADDR_HI: begin
        temp_a_d[15:8] = I_MEM_RDATA;
        pc_d = pc_q + STEP_ONE;
        addr_d = pc_q + STEP_ONE;
        rd_d = 1'b1;
        state_d = ST_ADDR_LO;
      end
      // low byte completes counter A; main counter then held
      ST_ADDR_LO: begin
        temp_a_d = operand_addr;
        pc_d = pc_q + STEP_ONE;
        case (mode_q)
          // big absolute: first data byte at the operand address
          MODE_BIG_ABS: begin
            addr_d = operand_addr;
            rd_d = !is_wide_store(op_q);
            wr_d = is_wide_store(op_q);
            wdata_d = wide_src[15:8];
            state_d = ST_WIDE_HI;
          end
          MODE_INDEXED: begin
            if (is_jump(op_q)) begin
              pc_d = indexed_sum;
              state_d = ST_DONE;
            end else begin
              addr_d = indexed_sum;
              rd_d = (op_q != OP_STORE_WORKING_REG);
              wr_d = (op_q == OP_STORE_WORKING_REG);
              wdata_d = work_q;
              state_d = ST_DATA;
            end
          end
          // counter A points at the second address
          MODE_INDIRECT: begin
            addr_d = operand_addr;
            rd_d = 1'b1;
            state_d = ST_PTR_HI;
          end
          // counter A plus index points at the second address
          default: begin
            addr_d = indexed_sum;
            rd_d = 1'b1;
            state_d = ST_PTR_HI;
          end
        endcase
      end
      ST_PTR_HI: begin
        temp_b_d[15:8] = I_MEM_RDATA;
        // counter A steps on in indirect mode
        if (mode_q == MODE_INDIRECT) begin
          temp_a_d = temp_a_q + STEP_ONE;
        end
        // next byte, wrapping past the top
        addr_d = addr_q + STEP_ONE;
        rd_d = 1'b1;
        state_d = ST_PTR_LO;
      end
      ST_PTR_LO: begin
        temp_b_d[7:0] = I_MEM_RDATA;
        if (is_jump(op_q)) begin
          // fetched second address becomes the counter
          pc_d = {temp_b_q[15:8], I_MEM_RDATA};
          state_d = ST_DONE;
        end else begin
          addr_d = {temp_b_q[15:8], I_MEM_RDATA};
          rd_d = (op_q != OP_STORE_WORKING_REG);
          wr_d = (op_q == OP_STORE_WORKING_REG);
          wdata_d = work_q;
          state_d = ST_DATA;
        end
      end
      // data byte into the working register; a store writes at the edge ending this state
      ST_DATA: begin
        if (rd_q) begin
          work_d = alu(op_q, work_q, I_MEM_RDATA, I_CARRY);
        end
        state_d = ST_DONE;
      end
      // high data byte, then counter A steps to the low byte
      ST_WIDE_HI: begin
        case (op_q)
          OP_WIDE_LOAD_STACK_PTR: sp_d[15:8] = I_MEM_RDATA;
          OP_WIDE_LOAD_OFFSET_REG: index_d[15:8] = I_MEM_RDATA;
          OP_WIDE_LOAD_VECTOR: iv_d[15:8] = I_MEM_RDATA;
          default: ;
        endcase
        temp_a_d = temp_a_q + STEP_ONE;
        addr_d = addr_q + STEP_ONE;
        rd_d = !is_wide_store(op_q);
        wr_d = is_wide_store(op_q);
        wdata_d = wide_src[7:0];
        state_d = ST_WIDE_LO;
      end
      // low data byte into the low half
      ST_WIDE_LO: begin
        case (op_q)
          OP_WIDE_LOAD_STACK_PTR: sp_d[7:0] = I_MEM_RDATA;
          OP_WIDE_LOAD_OFFSET_REG: index_d[7:0] = I_MEM_RDATA;
          OP_WIDE_LOAD_VECTOR: iv_d[7:0] = I_MEM_RDATA;
          default: ;
        endcase
        state_d = ST_DONE;
      end
      // control returns to the main counter
      ST_DONE: begin
        done_d = 1'b1;
        busy_d = 1'b0;
        state_d = ST_IDLE;
      end
      default: begin
        busy_d = 1'b0;
        state_d = ST_IDLE;
      end
    endcase
  end

  // registers only; synchronous active-low reset
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      state_q <= ST_IDLE;
      mode_q <= MODE_BIG_ABS;
      op_q <= OP_ADD;
      pc_q <= RST_WORD;
      ir_q <= RST_BYTE;
      temp_a_q <= RST_WORD;
      temp_b_q <= RST_WORD;
      index_q <= RST_WORD;
      sp_q <= RST_WORD;
      iv_q <= RST_WORD;
      work_q <= RST_BYTE;
      addr_q <= RST_WORD;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      wdata_q <= RST_BYTE;
      done_q <= 1'b0;
      busy_q <= 1'b0;
      illegal_q <= 1'b0;
    end else begin
      state_q <= state_d;
      mode_q <= mode_d;
      op_q <= op_d;
      pc_q <= pc_d;
      ir_q <= ir_d;
      temp_a_q <= temp_a_d;
      temp_b_q <= temp_b_d;
      index_q <= index_d;
      sp_q <= sp_d;
      iv_q <= iv_d;
      work_q <= work_d;
      addr_q <= addr_d;
      rd_q <= rd_d;
      wr_q <= wr_d;
      wdata_q <= wdata_d;
      done_q <= done_d;
      busy_q <= busy_d;
      illegal_q <= illegal_d;
    end
  end

  // every output straight from a flip-flop
  assign O_MEM_ADDR = addr_q;
  assign O_MEM_RD = rd_q;
  assign O_MEM_WR = wr_q;
  assign O_MEM_WDATA = wdata_q;
  assign O_BUSY = busy_q;
  assign O_DONE = done_q;
  assign O_ILLEGAL = illegal_q;
  assign O_PROGRAM_COUNTER = pc_q;
  assign O_OPCODE_HOLDING_REGISTER = ir_q;
  assign O_WORKING_REGISTER = work_q;
  assign O_INDEX_REG = index_q;
  assign O_STACK_POINTER = sp_q;
  assign O_INTERRUPT_VECTOR = iv_q;

endmodule

// >>> testbench/byte_memory.sv
`timescale 1ns/1ps
// asynchronous-read byte memory on the far side of the sequencer
module byte_memory (
  input wire logic i_clk,
  input wire logic [15:0] i_addr,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_q = 8'h00;
  // write on the edge ending the strobe; remember the last byte read
  always @(posedge i_clk) begin
    if (i_wr) mem[i_addr] <= i_wdata;
    if (i_rd) last_q <= mem[i_addr];
  end
  // outside a read the bus shows the inverse, so stale data never passes
  assign o_rdata = i_rd ? mem[i_addr] : ~last_q;
endmodule

// >>> testbench/seq_checker_assertions.sv
`timescale 1ns/1ps
module seq_checker
  import addr_seq_pkg::*;
(
  input wire logic I_REF_CLK,
  input wire logic I_RSTN,
  input wire logic I_START,
  input wire logic [1:0] I_MODE,
  input wire logic [4:0] I_OP,
  input wire logic [15:0] O_MEM_ADDR,
  input wire logic O_MEM_RD,
  input wire logic O_MEM_WR,
  input wire logic [7:0] O_MEM_WDATA,
  input wire logic O_BUSY,
  input wire logic O_DONE,
  input wire logic O_ILLEGAL,
  input wire logic [15:0] O_PROGRAM_COUNTER,
  input wire logic [7:0] O_WORKING_REGISTER,
  input wire logic [15:0] O_INDEX_REG
);
  logic [1:0] mode_d;
  logic [1:0] mode_q;
  logic take;
  logic legal;
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RSTN);
  // pairs of mode and class that the sequencer accepts
  assign legal = (I_MODE == MODE_BIG_ABS) ? (I_OP >= 5'h0c && I_OP <= 5'h10) :
    (I_MODE == MODE_INDEXED) ? (I_OP <= 5'h0b) : (I_OP == 5'h04 || I_OP == 5'h06 || I_OP == 5'h0a || I_OP == 5'h0b);
  assign take = I_START && !O_BUSY;
  // mode of the instruction in flight, for the per-mode checks
  always_comb mode_d = take ? I_MODE : mode_q;
  always_ff @(posedge I_REF_CLK) mode_q <= !I_RSTN ? 2'h0 : mode_d;
  property p_fetch;
    take && legal |=> O_BUSY && !O_ILLEGAL && O_MEM_RD && O_MEM_ADDR == $past(O_PROGRAM_COUNTER);
  endproperty
  a_fetch: assert property (p_fetch) else $error("opcode fetch wrong");
  property p_addr_seq;
    take && legal |=> ##1 O_MEM_RD && O_MEM_ADDR == $past(O_MEM_ADDR) + 16'h0001
      ##1 O_MEM_RD && O_MEM_ADDR == $past(O_MEM_ADDR) + 16'h0001;
  endproperty
  a_addr_seq: assert property (p_addr_seq) else $error("operand fetch order wrong");
  property p_done;
    take && legal |=> ##[4:7] O_DONE;
  endproperty
  a_done: assert property (p_done) else $error("instruction did not finish");
  property p_illegal;
    take && !legal |=> O_ILLEGAL && !O_BUSY && !O_MEM_RD;
  endproperty
  a_illegal: assert property (p_illegal) else $error("bad pair not refused");
  property p_pulse;
    O_DONE && !I_START |=> !O_DONE && !O_BUSY;
  endproperty
  a_pulse: assert property (p_pulse) else $error("done not a single pulse");
  property p_quiet;
    !O_BUSY |-> !O_MEM_RD && !O_MEM_WR;
  endproperty
  a_quiet: assert property (p_quiet) else $error("memory access while idle");
  property p_x_hold;
    $changed(O_INDEX_REG) |-> mode_q == MODE_BIG_ABS;
  endproperty
  a_x_hold: assert property (p_x_hold) else $error("index register disturbed");
  property p_wdata;
    O_MEM_WR && mode_q != MODE_BIG_ABS |-> O_MEM_WDATA == O_WORKING_REGISTER;
  endproperty
  a_wdata: assert property (p_wdata) else $error("store data wrong");
  property p_pair;
    O_MEM_WR && mode_q == MODE_BIG_ABS && !$past(O_MEM_WR) |=> O_MEM_WR && O_MEM_ADDR == $past(O_MEM_ADDR) + 16'h0001;
  endproperty
  a_pair: assert property (p_pair) else $error("wide store not a byte pair");
  c_illegal: cover property (O_ILLEGAL);
  c_big_store: cover property (O_MEM_WR && mode_q == MODE_BIG_ABS);
  c_preindexed: cover property (O_DONE && mode_q == MODE_PREINDEXED);
endmodule
bind cpu_addressing_sequencer seq_checker i_seq_checker (.I_REF_CLK, .I_RSTN, .I_START, .I_MODE, .I_OP,
  .O_MEM_ADDR, .O_MEM_RD, .O_MEM_WR, .O_MEM_WDATA, .O_BUSY, .O_DONE, .O_ILLEGAL, .O_PROGRAM_COUNTER,
  .O_WORKING_REGISTER, .O_INDEX_REG);

// >>> testbench/testbench.sv
`timescale 1ns/1ps
module testbench
  import addr_seq_pkg::*;
;
  logic I_REF_CLK = 1'b0;
  logic I_RSTN = 1'b0;
  logic I_START = 1'b0;
  logic I_CARRY = 1'b1;
  logic [1:0] I_MODE = 2'h0;
  logic [4:0] I_OP = 5'h00;
  wire logic [7:0] I_MEM_RDATA;
  logic [15:0] O_MEM_ADDR, O_PROGRAM_COUNTER, O_INDEX_REG, O_STACK_POINTER, O_INTERRUPT_VECTOR;
  logic [7:0] O_MEM_WDATA, O_OPCODE_HOLDING_REGISTER, O_WORKING_REGISTER;
  logic O_MEM_RD, O_MEM_WR, O_BUSY, O_DONE, O_ILLEGAL;
  int failures = 0;
  int checks_done = 0;
  logic [15:0] epc = 16'h0000;
  logic [7:0] ewr = 8'h00;
  logic [7:0] dat = 8'h35;
  cpu_addressing_sequencer i_cpu_addressing_sequencer (.I_REF_CLK, .I_RSTN, .I_START, .I_MODE, .I_OP,
    .I_CARRY, .I_MEM_RDATA, .O_MEM_ADDR, .O_MEM_RD, .O_MEM_WR, .O_MEM_WDATA, .O_BUSY, .O_DONE, .O_ILLEGAL,
    .O_PROGRAM_COUNTER, .O_OPCODE_HOLDING_REGISTER, .O_WORKING_REGISTER, .O_INDEX_REG, .O_STACK_POINTER,
    .O_INTERRUPT_VECTOR);
  byte_memory i_byte_memory (.i_clk(I_REF_CLK), .i_addr(O_MEM_ADDR), .i_rd(O_MEM_RD), .i_wr(O_MEM_WR),
    .i_wdata(O_MEM_WDATA), .o_rdata(I_MEM_RDATA));
  // 200 MHz reference clock
  initial forever #2.5 I_REF_CLK = ~I_REF_CLK;
  task automatic results;
    if (failures == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic put(input logic [15:0] a, input logic [7:0] d);
    i_byte_memory.mem[a] = d;
  endtask
  // one instruction at the expected counter; jumps land on jt
  task automatic run(input logic [1:0] m, input logic [4:0] op, input logic [15:0] opnd, input logic [15:0] jt);
    int n;
    put(epc, 8'h5a);
    put(epc + 16'h0001, opnd[15:8]);
    put(epc + 16'h0002, opnd[7:0]);
    @(negedge I_REF_CLK);
    I_START = 1'b1;
    I_MODE = m;
    I_OP = op;
    @(negedge I_REF_CLK);
    I_START = 1'b0;
    n = 0;
    while (O_DONE !== 1'b1 && n < 20) begin
      @(negedge I_REF_CLK);
      n++;
    end
    if (n == 20) begin
      failures++;
      results();
    end
    @(negedge I_REF_CLK);
    epc = (op == OP_JUMP_ALWAYS || op == OP_CALL_SUBROUTINE) ? jt : epc + 16'h0003;
    check("counter", O_PROGRAM_COUNTER, epc);
    check("holding", O_OPCODE_HOLDING_REGISTER, 8'h5a);
  endtask
  task automatic s_wide;
    put(16'h1234, 8'hab);
    put(16'h1235, 8'hcd);
    put(16'hffff, 8'h12);
    run(MODE_BIG_ABS, OP_WIDE_LOAD_OFFSET_REG, 16'h1234, 16'h0000);
    check("index", O_INDEX_REG, 16'habcd);
    run(MODE_BIG_ABS, OP_WIDE_LOAD_VECTOR, 16'h1234, 16'h0000);
    check("vector", O_INTERRUPT_VECTOR, 16'habcd);
    run(MODE_BIG_ABS, OP_WIDE_LOAD_STACK_PTR, 16'hffff, 16'h0000);
    check("stack", O_STACK_POINTER, 16'h125a);
    run(MODE_BIG_ABS, OP_WIDE_STORE_STACK_PTR, 16'h2000, 16'h0000);
    run(MODE_BIG_ABS, OP_WIDE_STORE_OFFSET_REG, 16'h2002, 16'h0000);
    check("sp pair", {i_byte_memory.mem[16'h2000], i_byte_memory.mem[16'h2001]}, 16'h125a);
    check("x pair", {i_byte_memory.mem[16'h2002], i_byte_memory.mem[16'h2003]}, 16'habcd);
  endtask
  // every computing class through sum 6000+abcd, wrapping to 0bcd
  task automatic s_indexed;
    put(16'h0bcd, dat);
    for (int k = 0; k < 10; k++) begin
      // carry low only for the borrow form, so both carry levels are seen
      I_CARRY = (k == 8) ? 1'b0 : 1'b1;
      // clear the byte first so the store has to really write it
      if (k == 6) put(16'h0bcd, 8'h00);
      run(MODE_INDEXED, k[4:0], 16'h6000, 16'h0000);
      case (k)
        0: ewr = ewr + dat;
        1: ewr = ewr + dat + 8'h01;
        2: ewr = ewr & dat;
        4: ewr = dat;
        5: ewr = ewr | dat;
        6: dat = ewr;
        7: ewr = ewr - dat;
        8: ewr = ewr - dat;
        9: ewr = ewr ^ dat;
        default: ;
      endcase
      check("working", O_WORKING_REGISTER, ewr);
      check("data", i_byte_memory.mem[16'h0bcd], dat);
    end
    check("index", O_INDEX_REG, 16'habcd);
    run(MODE_INDEXED, OP_JUMP_ALWAYS, 16'h1000, 16'hbbcd);
    run(MODE_INDEXED, OP_CALL_SUBROUTINE, 16'h4433, 16'hf000);
  endtask
  task automatic s_indirect;
    put(16'h3000, 8'h40);
    put(16'h3001, 8'h10);
    put(16'h4010, 8'h99);
    put(16'h3002, 8'h41);
    put(16'h3003, 8'h20);
    run(MODE_INDIRECT, OP_LOAD_WORKING_REG, 16'h3000, 16'h0000);
    check("working", O_WORKING_REGISTER, 8'h99);
    run(MODE_INDIRECT, OP_STORE_WORKING_REG, 16'h3002, 16'h0000);
    check("stored", i_byte_memory.mem[16'h4120], 8'h99);
    run(MODE_INDIRECT, OP_JUMP_ALWAYS, 16'h3000, 16'h4010);
  endtask
  // pointer at 5000+abcd; 5432 puts the pointer across the top of memory
  task automatic s_preindexed;
    put(16'hfbcd, 8'h22);
    put(16'hfbce, 8'h33);
    put(16'h2233, 8'h5c);
    run(MODE_PREINDEXED, OP_LOAD_WORKING_REG, 16'h5000, 16'h0000);
    check("working", O_WORKING_REGISTER, 8'h5c);
    run(MODE_PREINDEXED, OP_CALL_SUBROUTINE, 16'h5000, 16'h2233);
    run(MODE_PREINDEXED, OP_STORE_WORKING_REG, 16'h5432, 16'h0000);
    check("stored", i_byte_memory.mem[16'h125a], 8'h5c);
  endtask
  task automatic bad(input logic [1:0] m, input logic [4:0] op);
    @(negedge I_REF_CLK);
    I_START = 1'b1;
    I_MODE = m;
    I_OP = op;
    @(negedge I_REF_CLK);
    I_START = 1'b0;
    check("illegal", O_ILLEGAL, 1'b1);
    check("busy", O_BUSY, 1'b0);
    check("counter", O_PROGRAM_COUNTER, epc);
  endtask
  task automatic s_illegal;
    bad(MODE_INDIRECT, OP_ADD);
    bad(MODE_BIG_ABS, OP_LOAD_WORKING_REG);
    bad(MODE_INDEXED, OP_WIDE_LOAD_VECTOR);
    bad(MODE_PREINDEXED, OP_XOR);
  endtask
  // reset for eight cycles, then the scenarios in turn
  initial begin
    repeat (8) @(negedge I_REF_CLK);
    I_RSTN = 1'b1;
    s_wide();
    s_indexed();
    s_indirect();
    s_preindexed();
    s_illegal();
    results();
  end
endmodule
